/* rtl/fifo_clear_pkg.sv */
// constants, types and helpers shared by the clearable fifo and its pointer synchroniser
// Operation
// - lowest-latency group: one sync stage, no protection
// - minimal unsynchronised group: two sync stages
// - best-protection group: three or more stages
// - newer families: stages equal parameter minus two
// - reduced default three gives one stage
// - offer synchronous and asynchronous clear inputs
// - async clear, applied directly to the flops with no synchroniser
// - either clear deasserts full and almost full
// - either clear asserts empty and almost empty
// - either clear zeroes the fill level count
// - either clear zeroes read and write pointers
// - synchronous clear acts only at rising edge
// - async clear hits pointers and flags immediately
// - normal aclr: read data keeps its value
// - lookahead select picks normal or lookahead mode
package fifo_clear_pkg;

    typedef enum logic [1:0] {
        GROUP_CUSTOM,
        GROUP_LOWEST,
        GROUP_MINIMAL,
        GROUP_BEST
    } syncGroup_type;

    localparam int LOWEST_STAGES = 1;
    localparam int MINIMAL_STAGES = 2;
    localparam int BEST_STAGES = 3;
    localparam int DEPTH_REDUCTION = 2;
    localparam int PIPE_PARAM_DEFAULT = 3;
    localparam int MIN_STAGES = 1;

    // apb register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] XSYNC_OFFSET = 8'h08;
    localparam logic [7:0] CFG_OFFSET = 8'h0C;

    localparam int CTRL_CLEAR_BIT = 0;
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_AFULL_BIT = 1;
    localparam int STAT_EMPTY_BIT = 2;
    localparam int STAT_AEMPTY_BIT = 3;
    localparam int STAT_USED_LSB = 8;
    localparam int XSYNC_WR_LSB = 0;
    localparam int XSYNC_RD_LSB = 16;
    localparam int CFG_WR_LSB = 0;
    localparam int CFG_RD_LSB = 8;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;

    // stage count chosen by group setting, or derived from a pipeline parameter
    function automatic int syncStages(syncGroup_type grp, int pipeParam, bit newerFamily);
        int stages;
        stages = pipeParam;
        unique case (grp)
            GROUP_LOWEST: stages = LOWEST_STAGES;
            GROUP_MINIMAL: stages = MINIMAL_STAGES;
            GROUP_BEST: stages = (pipeParam - (newerFamily ? DEPTH_REDUCTION : 0) > BEST_STAGES)
                ? pipeParam - (newerFamily ? DEPTH_REDUCTION : 0) : BEST_STAGES;
            GROUP_CUSTOM: stages = newerFamily ? pipeParam - DEPTH_REDUCTION : pipeParam;
        endcase
        if (stages < MIN_STAGES) begin
            stages = MIN_STAGES;
        end
        return stages;
    endfunction

endpackage

/* rtl/fifo_clear_sync.sv */
// single-clock fifo with synchronous and asynchronous clears and pointer synchronisers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
module fifo_clear_sync
    import fifo_clear_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 4,
    parameter int AFULL_LEVEL = 12,
    parameter int AEMPTY_LEVEL = 4,
    parameter bit lookahead_output_select = 1'b0,
    parameter bit registeredOutput = 1'b0,
    parameter bit newerFamily = 1'b1,
    parameter syncGroup_type syncGroup = GROUP_CUSTOM,
    parameter int write_side_sync_depth_param = PIPE_PARAM_DEFAULT,
    parameter int read_side_sync_depth_param = PIPE_PARAM_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic aclr,
    input wire logic sclr,
    input wire logic wrReq,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic rdReq,
    output logic [DATA_W-1:0] rdData,
    output logic full,
    output logic almostFull,
    output logic empty,
    output logic almostEmpty,
    output logic [ADDR_W:0] usedWords,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [ADDR_W:0] DEPTH_COUNT = (ADDR_W + 1)'(DEPTH);
    localparam logic [ADDR_W:0] AFULL_COUNT = (ADDR_W + 1)'(AFULL_LEVEL);
    localparam logic [ADDR_W:0] AEMPTY_COUNT = (ADDR_W + 1)'(AEMPTY_LEVEL);
    localparam int WR_STAGES = syncStages(syncGroup, write_side_sync_depth_param, newerFamily);
    localparam int RD_STAGES = syncStages(syncGroup, read_side_sync_depth_param, newerFamily);

    // pointer and flag state, cleared at once by aclr or arst_n
    logic clrN;
    logic clearNow;
    logic doWrite;
    logic doRead;
    logic [ADDR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [ADDR_W:0] used_q, used_d;
    logic full_q, full_d, afull_q, afull_d, empty_q, empty_d, aempty_q, aempty_d;

    // read-data state, aclr does not reset it; only arst_n resets it asynchronously
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] lastAddr_q, lastAddr_d, showAddr_q, showAddr_d;
    logic [DATA_W-1:0] qReg_q, qReg_d;

    // register bus state
    logic softClear_q, softClear_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [ADDR_W-1:0] wrPtrSynced, rdPtrSynced;

    // combined clear keeps a single async control on the pointer flops
    assign clrN = arst_n & ~aclr;

    always_comb begin
        clearNow = sclr | softClear_q;
        doWrite = wrReq & ~full_q & ~clearNow;
        doRead = rdReq & ~empty_q & ~clearNow;
        if (clearNow) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            used_d = '0;
        end else begin
            wrPtr_d = wrPtr_q + ADDR_W'(doWrite);
            rdPtr_d = rdPtr_q + ADDR_W'(doRead);
            used_d = used_q + (ADDR_W + 1)'(doWrite) - (ADDR_W + 1)'(doRead);
        end
        full_d = ~clearNow & (used_d == DEPTH_COUNT);
        afull_d = ~clearNow & (used_d >= AFULL_COUNT);
        empty_d = clearNow | (used_d == '0);
        aempty_d = clearNow | (used_d < AEMPTY_COUNT);
    end

    always_ff @(posedge clk_sys or negedge clrN) begin
        if (!clrN) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            used_q <= '0;
            full_q <= 1'b0;
            afull_q <= 1'b0;
            empty_q <= 1'b1;
            aempty_q <= 1'b1;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            used_q <= used_d;
            full_q <= full_d;
            afull_q <= afull_d;
            empty_q <= empty_d;
            aempty_q <= aempty_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            mem[wrPtr_q] <= wrData;
        end
    end

    // read-data path; aclr does not reset it, so normal-mode data holds through the clear while the lookahead address follows the zeroed pointer
    always_comb begin
        lastAddr_d = lastAddr_q;
        if (clearNow) begin
            lastAddr_d = '0;
        end else if (doRead) begin
            lastAddr_d = rdPtr_q;
        end
        // lookahead address lags a sync clear by one edge, follows aclr at the first edge
        showAddr_d = clearNow ? showAddr_q : rdPtr_d;
        qReg_d = qReg_q;
        if (!aclr && !clearNow) begin
            if (lookahead_output_select) begin
                qReg_d = mem[rdPtr_d];
            end else if (doRead) begin
                qReg_d = mem[rdPtr_q];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lastAddr_q <= '0;
            showAddr_q <= '0;
            qReg_q <= '0;
        end else begin
            lastAddr_q <= lastAddr_d;
            showAddr_q <= showAddr_d;
            qReg_q <= qReg_d;
        end
    end

    // unregistered mode reads the array directly; the first lookahead word after a clear
    // is stale until the user writes
    assign rdData = registeredOutput ? qReg_q
        : mem[lookahead_output_select ? showAddr_q : lastAddr_q];
    assign full = full_q;
    assign almostFull = afull_q;
    assign empty = empty_q;
    assign almostEmpty = aempty_q;
    assign usedWords = used_q;

    // pointer crossings; depth set by group setting or pipeline parameters
    sync_chain #(.STAGES(WR_STAGES), .WIDTH(ADDR_W)) wrPtrCross (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din(wrPtr_q),
        .dout(wrPtrSynced)
    );
    sync_chain #(.STAGES(RD_STAGES), .WIDTH(ADDR_W)) rdPtrCross (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din(rdPtr_q),
        .dout(rdPtrSynced)
    );

    // apb slave: one wait state, write commits at the edge that sees pready high
    always_comb begin
        logic [31:0] rd;
        rd = REG_ZERO;
        pready_d = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        softClear_d = 1'b0;
        unique case (paddr)
            CTRL_OFFSET: rd = REG_ZERO;
            STATUS_OFFSET: begin
                rd[STAT_FULL_BIT] = full_q;
                rd[STAT_AFULL_BIT] = afull_q;
                rd[STAT_EMPTY_BIT] = empty_q;
                rd[STAT_AEMPTY_BIT] = aempty_q;
                rd[STAT_USED_LSB +: ADDR_W + 1] = used_q;
            end
            XSYNC_OFFSET: begin
                rd[XSYNC_WR_LSB +: ADDR_W] = wrPtrSynced;
                rd[XSYNC_RD_LSB +: ADDR_W] = rdPtrSynced;
            end
            CFG_OFFSET: begin
                rd[CFG_WR_LSB +: 8] = 8'(WR_STAGES);
                rd[CFG_RD_LSB +: 8] = 8'(RD_STAGES);
            end
            default: pslverr_d = pready_d;
        endcase
        if (!pready_d) begin
            pslverr_d = 1'b0;
        end
        prdata_d = (pready_d && !pwrite) ? rd : REG_ZERO;
        if (psel && penable && pready_q && pwrite && paddr == CTRL_OFFSET) begin
            softClear_d = pwdata[CTRL_CLEAR_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= REG_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            softClear_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            softClear_q <= softClear_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    a_clear_flags_low: assert property (@(posedge clk_sys) disable iff (!clrN)
        sclr |=> !full && !almostFull)
        else $error("full flags not dropped by clear");
    a_clear_empty_high: assert property (@(posedge clk_sys) disable iff (!clrN)
        sclr |=> empty && almostEmpty && usedWords == '0)
        else $error("empty flags or count wrong after clear");
    a_sclr_ptr_zero: assert property (@(posedge clk_sys) disable iff (!clrN)
        sclr |=> wrPtr_q == '0 && rdPtr_q == '0)
        else $error("pointers not zero after sync clear");
    a_count_stable_idle: assert property (@(posedge clk_sys) disable iff (!clrN)
        (!clearNow && !doWrite && !doRead) |=> $stable(usedWords))
        else $error("count moved without a request or clear");
    a_aclr_immediate: assert property (@(posedge clk_sys) disable iff (!arst_n)
        aclr |-> empty && !full && usedWords == '0 && rdPtr_q == '0)
        else $error("async clear not immediate on flags");
    a_aclr_q_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (aclr && !sclr && !softClear_q) |=> $stable(qReg_q) && $stable(lastAddr_q))
        else $error("read data moved under async clear");
    a_sclr_normal_first: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sclr |=> lastAddr_q == '0)
        else $error("normal mode not at first word after clear");
    a_sclr_lookahead: assert property (@(posedge clk_sys) disable iff (!clrN)
        (sclr && !softClear_q) ##1 !sclr |-> $stable(showAddr_q) ##1 showAddr_q == '0)
        else $error("lookahead clear timing wrong");
    a_aclr_lookahead: assert property (@(posedge clk_sys) disable iff (!arst_n)
        aclr |=> showAddr_q == '0)
        else $error("lookahead not at first word after async clear");
    a_clear_priority: assert property (@(posedge clk_sys) disable iff (!clrN)
        (sclr && (wrReq || rdReq)) |=> usedWords == '0)
        else $error("request taken during sync clear");
endmodule // fifo_clear_sync

/* rtl/sync_chain.sv */
// flip-flop chain that carries a pointer word across a clock boundary
`timescale 1ns/10ps
module sync_chain
    import fifo_clear_pkg::*;
#(
    parameter int STAGES = 2,
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage_q [STAGES];
    logic [WIDTH-1:0] stage_d [STAGES];

    // a single stage gives no metastability margin, only valid for related clocks
    generate
        for (genvar i = 0; i < STAGES; i++) begin : g_stage
            always_comb begin
                stage_d[i] = (i == 0) ? din : stage_q[(i == 0) ? 0 : i - 1];
            end
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    stage_q[i] <= '0;
                end else begin
                    stage_q[i] <= stage_d[i];
                end
            end
        end
    endgenerate

    assign dout = stage_q[STAGES-1];
endmodule // sync_chain

/* tb/fifo_clear_and_sync_depth_tb.sv */
// self-checking bench for the clearable fifo: clears, lookahead output and stage settings
`timescale 1ns/10ps
module fifo_clear_and_sync_depth_tb;
    import fifo_clear_pkg::*;
    logic clk_sys, arst_n, aclr, sclr, psel, penable, pwrite, pready, pslverr;
    logic full, almostFull, empty, almostEmpty, wrReq, rdReq;
    logic fullLa, almostFullLa, emptyLa, almostEmptyLa, preadyLa, pslverrLa;
    logic fullRg, almostFullRg, emptyRg, almostEmptyRg, preadyRg, pslverrRg;
    logic [2:0] lastErr;
    logic [7:0] paddr, wrData, rdData, rdDataLa, rdDataRg;
    logic [4:0] usedWords, usedWordsLa, usedWordsRg;
    logic [31:0] pwdata, prdata, prdataLa, prdataRg, lastRd, lastRdLa, lastRdRg;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    fifo_user_model user (.clk_sys(clk_sys), .wrReq(wrReq), .wrData(wrData), .rdReq(rdReq));
    // one clock feeds both pointer sides, so a single read-side stage is legal here
    fifo_clear_sync #(.write_side_sync_depth_param(4)) dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .aclr(aclr), .sclr(sclr), .wrReq(wrReq),
        .wrData(wrData), .rdReq(rdReq), .rdData(rdData), .full(full), .almostFull(almostFull),
        .empty(empty), .almostEmpty(almostEmpty), .usedWords(usedWords), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fifo_clear_sync #(.lookahead_output_select(1'b1), .newerFamily(1'b0),
        .syncGroup(GROUP_BEST)) dutLa (
        .clk_sys(clk_sys), .arst_n(arst_n), .aclr(aclr), .sclr(sclr), .wrReq(wrReq),
        .wrData(wrData), .rdReq(rdReq), .rdData(rdDataLa), .full(fullLa),
        .almostFull(almostFullLa), .empty(emptyLa), .almostEmpty(almostEmptyLa),
        .usedWords(usedWordsLa), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdataLa), .pready(preadyLa),
        .pslverr(pslverrLa));
    fifo_clear_sync #(.registeredOutput(1'b1)) dutRg (
        .clk_sys(clk_sys), .arst_n(arst_n), .aclr(aclr), .sclr(sclr), .wrReq(wrReq),
        .wrData(wrData), .rdReq(rdReq), .rdData(rdDataRg), .full(fullRg),
        .almostFull(almostFullRg), .empty(emptyRg), .almostEmpty(almostEmptyRg),
        .usedWords(usedWordsRg), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdataRg), .pready(preadyRg),
        .pslverr(pslverrRg));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // packed as full, almostFull, empty, almostEmpty, usedWords
    task automatic flags(input logic [8:0] exp);
        @(negedge clk_sys);
        check("flags", {23'h0, exp}, {23'h0, full, almostFull, empty, almostEmpty, usedWords});
        check("flagsLa", {23'h0, exp},
            {23'h0, fullLa, almostFullLa, emptyLa, almostEmptyLa, usedWordsLa});
        check("flagsRg", {23'h0, exp},
            {23'h0, fullRg, almostFullRg, emptyRg, almostEmptyRg, usedWordsRg});
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // request stands until the edge at which pready is seen high; only the timeout ends it
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        check("pready", 32'h0000_0003, {30'h0, preadyLa, preadyRg});
        lastRd = prdata;
        lastRdLa = prdataLa;
        lastRdRg = prdataRg;
        lastErr = {pslverr, pslverrLa, pslverrRg};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        arst_n = 1'b0;
        aclr = 1'b0;
        sclr = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        flags(9'h060);
        check("rdDataRg", 32'h0000_0000, {24'h0, rdDataRg});
        // stage count per group and family, straight from the shared helper
        check("lowest", 32'h0000_0001, 32'(syncStages(GROUP_LOWEST, 9, 1'b1)));
        check("minimal", 32'h0000_0002, 32'(syncStages(GROUP_MINIMAL, 9, 1'b0)));
        check("best", 32'h0000_0006, 32'(syncStages(GROUP_BEST, 6, 1'b0)));
        check("older", 32'h0000_0005, 32'(syncStages(GROUP_CUSTOM, 5, 1'b0)));
        check("newer", 32'h0000_0002, 32'(syncStages(GROUP_CUSTOM, 4, 1'b1)));
        check("default", 32'h0000_0001, 32'(syncStages(GROUP_CUSTOM, 3, 1'b1)));
        // seventeenth word must be refused on a full fifo, or location 0 is overwritten
        for (int i = 0; i < 17; i++) begin
            user.push(8'h10 + 8'(i));
        end
        user.idle();
        flags(9'h190);
        user.pop();
        user.pop();
        user.idle();
        flags(9'h08E);
        check("rdData", 32'h0000_0011, {24'h0, rdData});
        check("rdDataLa", 32'h0000_0012, {24'h0, rdDataLa});
        check("rdDataRg", 32'h0000_0011, {24'h0, rdDataRg});
        // clear lands on the same edge as a write request
        user.push(8'h55);
        sclr <= 1'b1;
        flags(9'h08E);
        user.idle();
        sclr <= 1'b0;
        flags(9'h060);
        check("rdData", 32'h0000_0010, {24'h0, rdData});
        check("rdDataRg", 32'h0000_0011, {24'h0, rdDataRg});
        check("rdDataLa", 32'h0000_0012, {24'h0, rdDataLa});
        @(negedge clk_sys);
        check("rdDataLa", 32'h0000_0010, {24'h0, rdDataLa});
        user.push(8'hA0);
        user.push(8'hA1);
        user.pop();
        user.idle();
        flags(9'h021);
        check("rdData", 32'h0000_00A0, {24'h0, rdData});
        check("rdDataLa", 32'h0000_00A1, {24'h0, rdDataLa});
        check("rdDataRg", 32'h0000_00A0, {24'h0, rdDataRg});
        @(posedge clk_sys);
        aclr <= 1'b1;
        flags(9'h060);
        check("rdData", 32'h0000_00A0, {24'h0, rdData});
        check("rdDataRg", 32'h0000_00A0, {24'h0, rdDataRg});
        check("rdDataLa", 32'h0000_00A1, {24'h0, rdDataLa});
        @(posedge clk_sys);
        aclr <= 1'b0;
        @(negedge clk_sys);
        check("rdDataLa", 32'h0000_00A0, {24'h0, rdDataLa});
        apb(1'b0, STATUS_OFFSET, REG_ZERO);
        check("status", 32'h0000_000C, lastRd);
        apb(1'b0, CFG_OFFSET, REG_ZERO);
        check("cfg", 32'h0000_0102, lastRd);
        check("cfgLa", 32'h0000_0303, lastRdLa);
        check("cfgRg", 32'h0000_0101, lastRdRg);
        apb(1'b0, 8'h10, REG_ZERO);
        check("pslverr", 32'h0000_0007, {29'h0, lastErr});
        check("unmapped", 32'h0000_0000, lastRd);
        user.push(8'h77);
        user.push(8'h78);
        user.idle();
        apb(1'b0, STATUS_OFFSET, REG_ZERO);
        check("status", 32'h0000_0208, lastRd);
        check("pslverr", 32'h0000_0000, {29'h0, lastErr});
        apb(1'b0, XSYNC_OFFSET, REG_ZERO);
        check("xsync", 32'h0000_0002, lastRd);
        check("xsyncLa", 32'h0000_0002, lastRdLa);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        apb(1'b0, STATUS_OFFSET, REG_ZERO);
        check("status", 32'h0000_000C, lastRd);
        check("statusRg", 32'h0000_000C, lastRdRg);
        wrap_up();
    end
endmodule // fifo_clear_and_sync_depth_tb

/* tb/fifo_user_model.sv */
// user-side model that issues write and read requests to the fifo
`timescale 1ns/10ps
module fifo_user_model (
    input wire logic clk_sys,
    output logic wrReq,
    output logic [7:0] wrData,
    output logic rdReq
);
    initial begin
        wrReq = 1'b0;
        wrData = 8'h00;
        rdReq = 1'b0;
    end

    // a valid write always comes before the lookahead head is trusted
    task automatic push(input logic [7:0] d);
        @(posedge clk_sys);
        wrReq <= 1'b1;
        wrData <= d;
    endtask

    task automatic pop();
        @(posedge clk_sys);
        wrReq <= 1'b0;
        wrData <= ~wrData;
        rdReq <= 1'b1;
    endtask

    // released data is inverted so a stale word can never pass for a fresh one
    task automatic idle();
        @(posedge clk_sys);
        wrReq <= 1'b0;
        rdReq <= 1'b0;
        wrData <= ~wrData;
    endtask
endmodule // fifo_user_model
